// >>> cpag_params.svh
`ifndef CPAG_PARAMS_SVH
`define CPAG_PARAMS_SVH

// Width of the extended pointer and of every address it forms.
`define CPAG_PTR_W 23
// Width of the low pointer part, the buffer start and the signed constant.
`define CPAG_LOW_W 16
// Width of the high pointer part.
`define CPAG_HIGH_W 7
// Reset value of the extended pointer.
`define CPAG_PTR_RST 23'h000000
// Reset value of the generated address.
`define CPAG_ADDR_RST 23'h000000
// Pointer steps for narrow and wide accesses.
`define CPAG_STEP_ONE 23'h000001
`define CPAG_STEP_TWO 23'h000002

`endif

// >>> cpag_pkg.sv
package cpag_pkg;

    // Operand forms of the coefficient-pointer indirect mode.
    typedef enum logic [2:0] {
        FORM_PLAIN,
        FORM_POST_INC,
        FORM_POST_DEC,
        FORM_OFFSET,
        FORM_PRE_ADD
    } cpag_form_t;

    // Access types an operand may serve.
    typedef enum logic [2:0] {
        ACC_DATA_SINGLE,
        ACC_DATA_LONG,
        ACC_MMR_SINGLE,
        ACC_MMR_LONG,
        ACC_BIT_SINGLE,
        ACC_BIT_PAIR,
        ACC_IO
    } cpag_acc_t;

endpackage

// >>> cpag_sext_add.sv
`timescale 1ns/100ps
`include "cpag_params.svh"

module cpag_sext_add (
    // Operands
    input wire logic [`CPAG_PTR_W-1:0] base,
    input wire logic [`CPAG_LOW_W-1:0] signed_offset_const,
    // Result
    output logic [`CPAG_PTR_W-1:0] sum
);

    logic [`CPAG_PTR_W-1:0] offset_ext;

    // The constant is signed, so its top bit fills the upper pointer bits.
    assign offset_ext = {{(`CPAG_PTR_W-`CPAG_LOW_W){signed_offset_const[`CPAG_LOW_W-1]}},
                         signed_offset_const};
    assign sum = base + offset_ext;

endmodule // cpag_sext_add

// >>> cpag_circ_add.sv
`timescale 1ns/100ps
`include "cpag_params.svh"

module cpag_circ_add (
    // Address before and after the buffer start
    input wire logic [`CPAG_PTR_W-1:0] raw_addr,
    output logic [`CPAG_PTR_W-1:0] final_addr,
    // Circular configuration
    input wire logic circ_enable,
    input wire logic [`CPAG_LOW_W-1:0] coef_buffer_start
);

    // Software keeps this sum below the top of data space, so no carry-out check is made.
    assign final_addr = circ_enable ?
        raw_addr + {{(`CPAG_PTR_W-`CPAG_LOW_W){1'b0}}, coef_buffer_start} : raw_addr;

endmodule // cpag_circ_add

// >>> cpag_top.sv
`timescale 1ns/100ps
`include "cpag_params.svh"

module cpag_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Address request
    input wire logic req_valid,
    input wire cpag_pkg::cpag_form_t req_form,
    input wire cpag_pkg::cpag_acc_t req_access,
    input wire logic req_in_parallel,
    input wire logic [`CPAG_LOW_W-1:0] signed_offset_const,
    // Pointer mode and buffer start
    input wire logic circ_enable,
    input wire logic [`CPAG_LOW_W-1:0] coef_buffer_start,
    // Direct pointer loads from the register path
    input wire logic load_high,
    input wire logic [`CPAG_HIGH_W-1:0] load_high_value,
    input wire logic load_low,
    input wire logic [`CPAG_LOW_W-1:0] load_low_value,
    // Generated access
    output logic addr_valid_q,
    output logic [`CPAG_PTR_W-1:0] addr_q,
    output cpag_pkg::cpag_acc_t addr_access_q,
    output logic req_error_q,
    // Pointer state
    output logic [`CPAG_PTR_W-1:0] extended_coef_pointer_q
);

    // Wide accesses are 32-bit data, 32-bit register accesses and register bit pairs.
    function automatic logic is_wide(input cpag_pkg::cpag_acc_t acc);
        is_wide = (acc == cpag_pkg::ACC_DATA_LONG) || (acc == cpag_pkg::ACC_MMR_LONG) ||
                  (acc == cpag_pkg::ACC_BIT_PAIR);
    endfunction

    // The two constant forms carry an instruction extension.
    function automatic logic has_const(input cpag_pkg::cpag_form_t form);
        has_const = (form == cpag_pkg::FORM_OFFSET) || (form == cpag_pkg::FORM_PRE_ADD);
    endfunction

    logic [`CPAG_LOW_W-1:0] coef_pointer_low;
    logic [`CPAG_HIGH_W-1:0] coef_pointer_high;
    logic [`CPAG_PTR_W-1:0] step;
    logic [`CPAG_PTR_W-1:0] const_sum;
    logic [`CPAG_PTR_W-1:0] raw_addr;
    logic [`CPAG_PTR_W-1:0] final_addr;
    logic [`CPAG_PTR_W-1:0] ptr_d;
    logic legal;
    logic accept;

    assign coef_pointer_low = extended_coef_pointer_q[`CPAG_LOW_W-1:0];
    assign coef_pointer_high = extended_coef_pointer_q[`CPAG_PTR_W-1:`CPAG_LOW_W];

    // A refused request leaves the pointer alone, so one refusal costs no write-back.
    assign legal = !(has_const(req_form) &&
                     (req_in_parallel || req_access == cpag_pkg::ACC_IO));
    assign accept = req_valid && legal;

    assign step = is_wide(req_access) ? `CPAG_STEP_TWO : `CPAG_STEP_ONE;

    cpag_sext_add u_const_add (
        .base(extended_coef_pointer_q),
        .signed_offset_const(signed_offset_const),
        .sum(const_sum)
    );

    // Address before the circular start is added.
    always_comb begin
        case (req_form)
            cpag_pkg::FORM_OFFSET: raw_addr = const_sum;
            cpag_pkg::FORM_PRE_ADD: raw_addr = const_sum;
            default: raw_addr = {coef_pointer_high, coef_pointer_low};
        endcase
    end

    cpag_circ_add u_circ_add (
        .raw_addr(raw_addr),
        .final_addr(final_addr),
        .circ_enable(circ_enable),
        .coef_buffer_start(coef_buffer_start)
    );

    // Next pointer; 23-bit sums carry across pages and wrap silently at the ends.
    always_comb begin
        case (req_form)
            cpag_pkg::FORM_POST_INC: ptr_d = extended_coef_pointer_q + step;
            cpag_pkg::FORM_POST_DEC: ptr_d = extended_coef_pointer_q - step;
            cpag_pkg::FORM_PRE_ADD: ptr_d = const_sum;
            default: ptr_d = extended_coef_pointer_q;
        endcase
    end

    // Pointer register. A direct load from the register path wins over a modification.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extended_coef_pointer_q <= `CPAG_PTR_RST;
        end else if (load_high || load_low) begin
            extended_coef_pointer_q <= {load_high ? load_high_value : coef_pointer_high,
                                        load_low ? load_low_value : coef_pointer_low};
        end else if (accept) begin
            extended_coef_pointer_q <= ptr_d;
        end
    end

    // Generated access, one cycle after the request.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_valid_q <= 1'b0;
            addr_q <= `CPAG_ADDR_RST;
            addr_access_q <= cpag_pkg::ACC_DATA_SINGLE;
        end else begin
            addr_valid_q <= accept;
            if (accept) begin
                addr_q <= final_addr;
                addr_access_q <= req_access;
            end
        end
    end

    // Refusal flag for a constant form run in parallel or aimed at I/O.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_error_q <= 1'b0;
        end else begin
            req_error_q <= req_valid && !legal;
        end
    end

    logic take;
    assign take = accept && !load_high && !load_low;

    property p_plain_keep;
        @(posedge clk) disable iff (!rst_n)
        take && req_form == cpag_pkg::FORM_PLAIN && !circ_enable |=>
            addr_q == $past(extended_coef_pointer_q) &&
            extended_coef_pointer_q == $past(extended_coef_pointer_q);
    endproperty
    a_plain_keep: assert property (p_plain_keep) else $error("bad plain access");

    property p_inc_one;
        @(posedge clk) disable iff (!rst_n)
        take && req_form == cpag_pkg::FORM_POST_INC && !is_wide(req_access) && !circ_enable |=>
            addr_q == $past(extended_coef_pointer_q) &&
            extended_coef_pointer_q == $past(extended_coef_pointer_q) + `CPAG_STEP_ONE;
    endproperty
    a_inc_one: assert property (p_inc_one) else $error("bad narrow increment");

    property p_inc_two;
        @(posedge clk) disable iff (!rst_n)
        take && req_form == cpag_pkg::FORM_POST_INC && is_wide(req_access) |=>
            extended_coef_pointer_q == $past(extended_coef_pointer_q) + `CPAG_STEP_TWO;
    endproperty
    a_inc_two: assert property (p_inc_two) else $error("bad wide increment");

    property p_dec_one;
        @(posedge clk) disable iff (!rst_n)
        take && req_form == cpag_pkg::FORM_POST_DEC && !is_wide(req_access) |=>
            extended_coef_pointer_q == $past(extended_coef_pointer_q) - `CPAG_STEP_ONE;
    endproperty
    a_dec_one: assert property (p_dec_one) else $error("bad narrow decrement");

    property p_dec_two;
        @(posedge clk) disable iff (!rst_n)
        take && req_form == cpag_pkg::FORM_POST_DEC && is_wide(req_access) && !circ_enable |=>
            addr_q == $past(extended_coef_pointer_q) &&
            extended_coef_pointer_q == $past(extended_coef_pointer_q) - `CPAG_STEP_TWO;
    endproperty
    a_dec_two: assert property (p_dec_two) else $error("bad wide decrement");

    property p_offset;
        @(posedge clk) disable iff (!rst_n)
        take && req_form == cpag_pkg::FORM_OFFSET && !circ_enable |=>
            addr_q == $past(extended_coef_pointer_q) +
                {{7{$past(signed_offset_const[15])}}, $past(signed_offset_const)} &&
            extended_coef_pointer_q == $past(extended_coef_pointer_q);
    endproperty
    a_offset: assert property (p_offset) else $error("bad offset address");

    property p_pre_add;
        @(posedge clk) disable iff (!rst_n)
        take && req_form == cpag_pkg::FORM_PRE_ADD && !circ_enable |=>
            addr_q == extended_coef_pointer_q &&
            extended_coef_pointer_q == $past(extended_coef_pointer_q) +
                {{7{$past(signed_offset_const[15])}}, $past(signed_offset_const)};
    endproperty
    a_pre_add: assert property (p_pre_add) else $error("bad pre-add");

    property p_circ;
        @(posedge clk) disable iff (!rst_n)
        take && circ_enable && req_form == cpag_pkg::FORM_POST_INC |=>
            addr_q == $past(extended_coef_pointer_q) + {7'h00, $past(coef_buffer_start)};
    endproperty
    a_circ: assert property (p_circ) else $error("buffer start not added");

    property p_refuse;
        @(posedge clk) disable iff (!rst_n)
        req_valid && has_const(req_form) && (req_in_parallel || req_access == cpag_pkg::ACC_IO)
            && !load_high && !load_low |=>
            req_error_q && !addr_valid_q && $stable(extended_coef_pointer_q);
    endproperty
    a_refuse: assert property (p_refuse) else $error("constant form not refused");

    property p_io_ok;
        @(posedge clk) disable iff (!rst_n)
        req_valid && req_access == cpag_pkg::ACC_IO && !has_const(req_form) |=>
            addr_valid_q && !req_error_q && addr_access_q == cpag_pkg::ACC_IO;
    endproperty
    a_io_ok: assert property (p_io_ok) else $error("I/O access wrongly refused");

    property p_once;
        @(posedge clk) disable iff (!rst_n)
        !req_valid && !load_high && !load_low |=> $stable(extended_coef_pointer_q);
    endproperty
    a_once: assert property (p_once) else $error("pointer moved without request");

    property p_load_both;
        @(posedge clk) disable iff (!rst_n)
        load_high && load_low |=>
            extended_coef_pointer_q == {$past(load_high_value), $past(load_low_value)};
    endproperty
    a_load_both: assert property (p_load_both) else $error("bad full load");

    // Loading one part must leave the other part alone.
    property p_load_low;
        @(posedge clk) disable iff (!rst_n)
        load_low && !load_high |=>
            extended_coef_pointer_q[22:16] == $past(extended_coef_pointer_q[22:16]) &&
            extended_coef_pointer_q[15:0] == $past(load_low_value);
    endproperty
    a_load_low: assert property (p_load_low) else $error("bad low load");

    property p_load_high;
        @(posedge clk) disable iff (!rst_n)
        load_high && !load_low |=>
            extended_coef_pointer_q[22:16] == $past(load_high_value) &&
            extended_coef_pointer_q[15:0] == $past(extended_coef_pointer_q[15:0]);
    endproperty
    a_load_high: assert property (p_load_high) else $error("bad high load");

    // A request beside a load still takes its address from the old pointer.
    property p_load_wins;
        @(posedge clk) disable iff (!rst_n)
        (load_high || load_low) && accept && !has_const(req_form) && !circ_enable |=>
            addr_valid_q && addr_q == $past(extended_coef_pointer_q);
    endproperty
    a_load_wins: assert property (p_load_wins) else $error("bad load address");

    property p_one_answer;
        @(posedge clk) disable iff (!rst_n)
        req_valid |=> addr_valid_q != req_error_q;
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("not one answer");

    property p_no_answer;
        @(posedge clk) disable iff (!rst_n)
        !req_valid |=> !addr_valid_q && !req_error_q;
    endproperty
    a_no_answer: assert property (p_no_answer) else $error("answer without request");

    property p_access;
        @(posedge clk) disable iff (!rst_n)
        accept |=> addr_access_q == $past(req_access);
    endproperty
    a_access: assert property (p_access) else $error("bad access type");

    // The far side may read the address late, so it must hold between requests.
    property p_addr_hold;
        @(posedge clk) disable iff (!rst_n)
        !accept |=> $stable(addr_q) && $stable(addr_access_q);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");

    // The buffer start also lands on the offset address.
    property p_circ_offset;
        @(posedge clk) disable iff (!rst_n)
        take && circ_enable && req_form == cpag_pkg::FORM_OFFSET |=>
            addr_q == $past(extended_coef_pointer_q) + {7'h00, $past(coef_buffer_start)} +
                {{7{$past(signed_offset_const[15])}}, $past(signed_offset_const)} &&
            extended_coef_pointer_q == $past(extended_coef_pointer_q);
    endproperty
    a_circ_offset: assert property (p_circ_offset) else $error("bad circular offset");

    property p_circ_dec;
        @(posedge clk) disable iff (!rst_n)
        take && circ_enable && req_form == cpag_pkg::FORM_POST_DEC && !is_wide(req_access) |=>
            addr_q == $past(extended_coef_pointer_q) + {7'h00, $past(coef_buffer_start)} &&
            extended_coef_pointer_q == $past(extended_coef_pointer_q) - `CPAG_STEP_ONE;
    endproperty
    a_circ_dec: assert property (p_circ_dec) else $error("bad circular decrement");

endmodule // cpag_top

// >>> cpag_mem_model.sv
`timescale 1ns/100ps

module cpag_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Accesses from the address generator
    input wire logic addr_valid_q,
    input wire logic [22:0] addr_q,
    input wire cpag_pkg::cpag_acc_t addr_access_q,
    // Accesses seen so far
    output logic [7:0] n_seen_q,
    output logic [22:0] last_addr_q,
    // I/O-space accesses seen so far
    output logic [7:0] n_io_q
);
    // Every accepted access is taken at once, as the real path never stalls here.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            n_seen_q <= 8'h00;
            last_addr_q <= 23'h000000;
            n_io_q <= 8'h00;
        end else if (addr_valid_q) begin
            n_seen_q <= n_seen_q + 8'h01;
            last_addr_q <= addr_q;
            if (addr_access_q == cpag_pkg::ACC_IO) begin
                n_io_q <= n_io_q + 8'h01;
            end
        end
    end
endmodule // cpag_mem_model

// >>> cpag_top_tb.sv
`timescale 1ns/100ps

module cpag_top_tb;
    logic clk, rst_n, req_valid, req_in_parallel, circ_enable, load_high, load_low;
    cpag_pkg::cpag_form_t req_form;
    cpag_pkg::cpag_acc_t req_access;
    logic [15:0] signed_offset_const, coef_buffer_start, load_low_value;
    logic [6:0] load_high_value;
    logic addr_valid_q, req_error_q;
    logic [22:0] addr_q, extended_coef_pointer_q, last_addr_q;
    cpag_pkg::cpag_acc_t addr_access_q;
    logic [7:0] n_seen_q, n_io_q;
    int failures = 0;
    int n_tests = 0;

    cpag_top i_cpag_top (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_form(req_form), .req_access(req_access), .req_in_parallel(req_in_parallel),
        .signed_offset_const(signed_offset_const), .circ_enable(circ_enable),
        .coef_buffer_start(coef_buffer_start), .load_high(load_high),
        .load_high_value(load_high_value), .load_low(load_low),
        .load_low_value(load_low_value), .addr_valid_q(addr_valid_q), .addr_q(addr_q),
        .addr_access_q(addr_access_q), .req_error_q(req_error_q),
        .extended_coef_pointer_q(extended_coef_pointer_q));
    cpag_mem_model i_cpag_mem_model (.clk(clk), .rst_n(rst_n), .addr_valid_q(addr_valid_q),
        .addr_q(addr_q), .addr_access_q(addr_access_q), .n_seen_q(n_seen_q),
        .last_addr_q(last_addr_q), .n_io_q(n_io_q));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic give_verdict();
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string what);
        n_tests++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    // One request, then its answer is judged in the single cycle it stands.
    // A quiet cycle follows, so back-to-back calls never reassign req_valid at once.
    task automatic do_req(input cpag_pkg::cpag_form_t f, input cpag_pkg::cpag_acc_t a,
        input logic [15:0] k, input logic par, input logic [22:0] ea, input logic [22:0] ep,
        input logic err);
        req_valid = 1'b1;
        req_form = f;
        req_access = a;
        signed_offset_const = k;
        req_in_parallel = par;
        @(negedge clk);
        req_valid = 1'b0;
        chk(addr_valid_q === !err && req_error_q === err, "answer kind");
        if (!err) chk(addr_q === ea && addr_access_q === a, "address");
        chk(extended_coef_pointer_q === ep, "pointer");
        @(negedge clk);
    endtask

    task automatic t_reset();
        chk(addr_valid_q === 1'b0 && req_error_q === 1'b0, "flags after reset");
        chk(addr_access_q === cpag_pkg::ACC_DATA_SINGLE && addr_q === 23'h000000, "addr rst");
        chk(extended_coef_pointer_q === 23'h000000, "pointer after reset");
    endtask

    // Full load, low part alone, then high part alone beside a request that it overrules.
    task automatic t_load();
        load_high = 1'b1;
        load_high_value = 7'h7f;
        load_low = 1'b1;
        load_low_value = 16'h1234;
        @(negedge clk);
        chk(extended_coef_pointer_q === 23'h7f1234, "full load");
        load_high = 1'b0;
        load_low_value = 16'hfffe;
        @(negedge clk);
        chk(extended_coef_pointer_q === 23'h7ffffe, "low load");
        load_high = 1'b1;
        load_high_value = 7'h01;
        load_low = 1'b0;
        req_valid = 1'b1;
        req_form = cpag_pkg::FORM_POST_INC;
        @(negedge clk);
        load_high = 1'b0;
        req_valid = 1'b0;
        chk(extended_coef_pointer_q === 23'h01fffe, "loaded pointer");
        chk(addr_valid_q === 1'b1 && addr_q === 23'h7ffffe, "address beside load");
        @(negedge clk);
    endtask

    task automatic t_post_modify();
        do_req(cpag_pkg::FORM_POST_INC, cpag_pkg::ACC_DATA_LONG, 16'h0000, 1'b0,
            23'h01fffe, 23'h020000, 1'b0);
        do_req(cpag_pkg::FORM_POST_INC, cpag_pkg::ACC_DATA_SINGLE, 16'h0000, 1'b0,
            23'h020000, 23'h020001, 1'b0);
        do_req(cpag_pkg::FORM_POST_DEC, cpag_pkg::ACC_BIT_SINGLE, 16'h0000, 1'b0,
            23'h020001, 23'h020000, 1'b0);
        do_req(cpag_pkg::FORM_POST_DEC, cpag_pkg::ACC_MMR_LONG, 16'h0000, 1'b0,
            23'h020000, 23'h01fffe, 1'b0);
        do_req(cpag_pkg::FORM_POST_INC, cpag_pkg::ACC_BIT_PAIR, 16'h0000, 1'b0,
            23'h01fffe, 23'h020000, 1'b0);
        do_req(cpag_pkg::FORM_POST_DEC, cpag_pkg::ACC_BIT_PAIR, 16'h0000, 1'b0,
            23'h020000, 23'h01fffe, 1'b0);
        do_req(cpag_pkg::FORM_POST_INC, cpag_pkg::ACC_IO, 16'h0000, 1'b0,
            23'h01fffe, 23'h01ffff, 1'b0);
    endtask

    task automatic t_constant_forms();
        do_req(cpag_pkg::FORM_PLAIN, cpag_pkg::ACC_MMR_SINGLE, 16'h0000, 1'b0,
            23'h01ffff, 23'h01ffff, 1'b0);
        do_req(cpag_pkg::FORM_OFFSET, cpag_pkg::ACC_DATA_SINGLE, 16'hfffd, 1'b0,
            23'h01fffc, 23'h01ffff, 1'b0);
        do_req(cpag_pkg::FORM_PRE_ADD, cpag_pkg::ACC_DATA_LONG, 16'h0003, 1'b0,
            23'h020002, 23'h020002, 1'b0);
        do_req(cpag_pkg::FORM_OFFSET, cpag_pkg::ACC_DATA_SINGLE, 16'h0001, 1'b1,
            23'h000000, 23'h020002, 1'b1);
        do_req(cpag_pkg::FORM_PRE_ADD, cpag_pkg::ACC_IO, 16'h0001, 1'b0,
            23'h000000, 23'h020002, 1'b1);
    endtask

    // Start value is kept small so the sum stays far below the top address.
    task automatic t_circular();
        circ_enable = 1'b1;
        coef_buffer_start = 16'h1000;
        do_req(cpag_pkg::FORM_PLAIN, cpag_pkg::ACC_DATA_SINGLE, 16'h0000, 1'b0,
            23'h021002, 23'h020002, 1'b0);
        do_req(cpag_pkg::FORM_POST_INC, cpag_pkg::ACC_DATA_SINGLE, 16'h0000, 1'b0,
            23'h021002, 23'h020003, 1'b0);
        do_req(cpag_pkg::FORM_OFFSET, cpag_pkg::ACC_DATA_SINGLE, 16'hfffd, 1'b0,
            23'h021000, 23'h020003, 1'b0);
        do_req(cpag_pkg::FORM_POST_DEC, cpag_pkg::ACC_DATA_SINGLE, 16'h0000, 1'b0,
            23'h021003, 23'h020002, 1'b0);
        circ_enable = 1'b0;
        do_req(cpag_pkg::FORM_PLAIN, cpag_pkg::ACC_DATA_SINGLE, 16'h0000, 1'b0,
            23'h020002, 23'h020002, 1'b0);
        chk(n_seen_q === 8'h10 && last_addr_q === 23'h020002, "accesses seen");
        chk(n_io_q === 8'h01, "I/O accesses seen");
    endtask

    initial begin
        #8000;
        failures++;
        give_verdict();
    end

    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_form = cpag_pkg::FORM_PLAIN;
        req_access = cpag_pkg::ACC_DATA_SINGLE;
        req_in_parallel = 1'b0;
        signed_offset_const = 16'h0000;
        circ_enable = 1'b0;
        coef_buffer_start = 16'h0000;
        load_high = 1'b0;
        load_high_value = 7'h00;
        load_low = 1'b0;
        load_low_value = 16'h0000;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset();
        t_load();
        t_post_modify();
        t_constant_forms();
        t_circular();
        give_verdict();
    end
endmodule // cpag_top_tb
